/* hdie_pkg.sv */
package hdie_pkg;

  // Register byte addresses
  localparam logic [11:0] ADDR_ENABLE = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_OVERSIZE = 12'h008;
  localparam logic [11:0] ADDR_OVS_EN = 12'h00C;
  localparam logic [11:0] ADDR_MASK = 12'h010;

  // Field positions of enable, status and mask, and of the oversize and oversize enable registers
  localparam int BIT_TX_START = 6;
  localparam int BIT_RX_START = 5;
  localparam int BIT_TX_END = 4;
  localparam int BIT_RX_END = 3;
  localparam int BIT_FCS_ERR = 2;
  localparam int BIT_ABORT = 1;
  localparam int BIT_IDLE = 0;
  localparam int BIT_OVERSIZE = 0;
  localparam int BIT_STAT_OVS = 7;

  // Reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic RST_OVS = 1'b0;

  // Writable bits of the enable register; bit 7 is reserved
  localparam logic [7:0] ENABLE_WMASK = 8'h7F;

  // Oversize threshold in bytes
  localparam int OVERSIZE_BYTES = 276;

  typedef struct packed {
    logic tx_start_event;
    logic rx_start_event;
    logic tx_end_event;
    logic rx_end_event;
    logic rx_buffer_full;
    logic frame_check_error;
    logic abort_seq;
    logic idle_flag;
    logic oversize_message;
  } hdie_events_t;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] status;
    logic [7:0] mask;
    logic ovs_status;
    logic ovs_en;
    logic [31:0] prdata;
    logic irq;
  } hdie_state_t;

endpackage : hdie_pkg

/* hdie_irq_ctrl.sv */
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module hdie_irq_ctrl
  import hdie_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Events from the data link engines
  input wire hdie_events_t events_in,
  // Interrupt
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  hdie_state_t state_reg;
  hdie_state_t state_next;

  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] ev_vec;
  logic [7:0] wbyte;

  always_comb
  begin
    ev_vec = 8'h00;
    ev_vec[BIT_TX_START] = events_in.tx_start_event;
    ev_vec[BIT_RX_START] = events_in.rx_start_event;
    ev_vec[BIT_TX_END] = events_in.tx_end_event;
    ev_vec[BIT_RX_END] = events_in.rx_end_event
                       | events_in.rx_buffer_full;
    ev_vec[BIT_FCS_ERR] = events_in.frame_check_error;
    ev_vec[BIT_ABORT] = events_in.abort_seq;
    ev_vec[BIT_IDLE] = events_in.idle_flag;
  end

  assign access = psel_in & penable_in;
  assign wr = access & pwrite_in;
  assign rd = access & ~pwrite_in;
  assign wbyte = pstrb_in[0] ? pwdata_in[7:0] : 8'h00;
  assign mapped = (paddr_in == ADDR_ENABLE) | (paddr_in == ADDR_STATUS)
                | (paddr_in == ADDR_OVERSIZE) | (paddr_in == ADDR_OVS_EN)
                | (paddr_in == ADDR_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    state_next = state_reg;
    state_next.prdata = 32'h0000_0000;
    // Sticky event status; set wins over write-one-to-clear
    if (wr && paddr_in == ADDR_STATUS)
    begin
      state_next.status[6:0] = state_reg.status[6:0] & ~wbyte[6:0];
    end
    state_next.status[6:0] = state_next.status[6:0] | ev_vec[6:0];
    // Oversize status: reset upon read, set wins over the read
    if ((rd && paddr_in == ADDR_OVERSIZE)
        || (wr && paddr_in == ADDR_OVERSIZE && wbyte[BIT_OVERSIZE]))
    begin
      state_next.ovs_status = 1'b0;
    end
    if (events_in.oversize_message)
    begin
      state_next.ovs_status = 1'b1;
    end
    state_next.status[BIT_STAT_OVS] = state_next.ovs_status;
    if (wr && pstrb_in[0])
    begin
      unique case (paddr_in)
        ADDR_ENABLE: state_next.enable = pwdata_in[7:0] & ENABLE_WMASK;
        ADDR_OVS_EN: state_next.ovs_en = pwdata_in[BIT_OVERSIZE];
        ADDR_MASK: state_next.mask = pwdata_in[7:0];
        default: ;
      endcase
    end
    if (rd)
    begin
      unique case (paddr_in)
        ADDR_ENABLE: state_next.prdata = {24'h000000, state_reg.enable};
        ADDR_STATUS: state_next.prdata = {24'h000000, state_reg.status};
        ADDR_OVERSIZE:
          state_next.prdata = {31'h0000_0000, state_reg.ovs_status};
        ADDR_OVS_EN: state_next.prdata = {31'h0000_0000, state_reg.ovs_en};
        ADDR_MASK: state_next.prdata = {24'h000000, state_reg.mask};
        default: state_next.prdata = 32'h0000_0000;
      endcase
    end
    // Interrupt: status gated by enable and mask
    state_next.irq = |(state_next.status[6:0] & state_next.enable[6:0]
                       & state_next.mask[6:0])
                   | (state_next.ovs_status & state_next.ovs_en
                      & state_next.mask[BIT_STAT_OVS]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_reg.enable <= RST_ENABLE;
      state_reg.status <= RST_STATUS;
      state_reg.mask <= RST_MASK;
      state_reg.ovs_status <= RST_OVS;
      state_reg.ovs_en <= RST_OVS;
      state_reg.prdata <= 32'h0000_0000;
      state_reg.irq <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Read data is registered, so every access takes one wait state
  logic ready_reg;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      ready_reg <= 1'b0;
    end
    else
    begin
      ready_reg <= access & ~ready_reg;
    end
  end

  assign pready_out = ready_reg;
  assign pslverr_out = ready_reg & ~mapped;
  assign prdata_out = state_reg.prdata;
  assign irq_out = state_reg.irq;

endmodule : hdie_irq_ctrl

`default_nettype wire

/* hdie_irq_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none
module hdie_props
  import hdie_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire hdie_events_t events_in,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  chk_ready_wait: assert property (
    psel_in && penable_in && !pready_out |=> pready_out) else $error("w");
  chk_ready_once: assert property (
    pready_out |=> !pready_out) else $error("o");
  chk_rsvd_zero: assert property (pready_out && !pwrite_in &&
    paddr_in == ADDR_ENABLE |-> prdata_out[31:7] == '0) else $error("r");
  chk_ovs_width: assert property (pready_out && !pwrite_in &&
    paddr_in == ADDR_OVERSIZE |-> prdata_out[31:1] == '0) else $error("v");
  chk_irq_cause: assert property ($rose(irq_out) |->
    |$past(events_in) || $past(psel_in) || $past(psel_in, 2))
    else $error("c");
  chk_irq_drop: assert property ($fell(irq_out) |->
    $past(psel_in) || $past(psel_in, 2)) else $error("d");
  chk_quiet_start: assert property ($past(reset_in) |->
    !irq_out && !pready_out) else $error("q");
  chk_map_ok: assert property (
    pready_out && paddr_in == ADDR_ENABLE |-> !pslverr_out) else $error("m");
endmodule : hdie_props
bind hdie_irq_ctrl hdie_props i_hdie_props (.*);
`default_nettype wire

/* hdie_evt_src.sv */
`timescale 1ns/1ps
`default_nettype none
module hdie_evt_src
  import hdie_pkg::*;
(
  input wire logic clk_in,
  input wire logic [8:0] req_in,
  output var hdie_events_t events_out
);
  // One-cycle event pulses from the engines
  always_ff @(posedge clk_in)
  begin
    events_out <= req_in;
  end
endmodule : hdie_evt_src
`default_nettype wire

/* hdie_irq_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %0t %h %h", $time, a, e); end end
module hdie_irq_ctrl_tb
  import hdie_pkg::*;
;
  logic clk_in = '0, reset_in = 1'b1, psel = '0, penable = '0, pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata_out;
  logic [8:0] req = '0;
  logic [7:0] r;
  logic pready_out, pslverr_out, irq_out;
  hdie_events_t ev;
  logic [31:0] q[$];
  logic [31:0] x;
  int miscompares = 0, num_checks = 0, e, b;
  hdie_evt_src i_hdie_evt_src (.clk_in, .req_in(req), .events_out(ev));
  hdie_irq_ctrl i_hdie_irq_ctrl (.clk_in, .reset_in, .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out, .pready_out,
    .pslverr_out, .events_in(ev), .irq_out);
  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    if (pready_out === 1'b1 && !pwrite && q.size() > 0)
    begin
      x = q.pop_front();
      `CHK(prdata_out, x)
    end
    if (pready_out === 1'b1)
      `CHK(pslverr_out, !(paddr inside {ADDR_ENABLE, ADDR_STATUS, ADDR_OVERSIZE, ADDR_OVS_EN, ADDR_MASK}))
  end
  task automatic close_out(input bit hung);
    miscompares += hung;
    $display("checks %0d bad %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_in);
    penable <= 1'b1;
    for (n = 0; n < 9 && pready_out !== 1'b1; n++) @(posedge clk_in);
    if (n == 9) close_out(1);
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic irq_is(input logic x);
    repeat (2) @(posedge clk_in);
    #1 `CHK(irq_out, x)
  endtask : irq_is
  task automatic pulse(input logic [8:0] v);
    req <= v;
    @(posedge clk_in);
    req <= '0;
  endtask : pulse
  initial
  begin
    r = 8'($urandom(53));
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(ADDR_ENABLE, 32'h0);
    r = 8'($urandom());
    apb(1'b1, ADDR_ENABLE, {24'h0, r});
    rd(ADDR_ENABLE, {24'h0, r & ENABLE_WMASK});
    for (e = 1; e < 9; e++)
    begin
      b = (e > 4) ? e - 2 : (e == 4) ? 3 : e - 1;
      apb(1'b1, ADDR_ENABLE, 32'h7F & ~(32'h1 << b));
      pulse(9'h1 << e);
      irq_is(1'b0);
      apb(1'b1, ADDR_ENABLE, 32'h1 << b);
      irq_is(1'b1);
      rd(ADDR_STATUS, 32'h1 << b);
      apb(1'b1, ADDR_STATUS, 32'h1 << b);
      irq_is(1'b0);
      $display("event test %0d done", e);
    end
    apb(1'b1, ADDR_OVS_EN, 32'h1);
    pulse(9'h001);
    irq_is(1'b1);
    rd(ADDR_OVERSIZE, 32'h1);
    rd(ADDR_OVERSIZE, 32'h0);
    irq_is(1'b0);
    rd(12'hFFC, 32'h0);
    repeat (2) @(posedge clk_in);
    $display("oversize test done");
    close_out(0);
  end
endmodule : hdie_irq_ctrl_tb
`default_nettype wire
